/* isa_legalizer.sv */
`include "machine_csr_consts.svh"

module isa_legalizer #(
	parameter logic [25:0] SUPPORTED = `EXT_SUPPORTED_RST,
	parameter logic [25:0] WRITABLE  = `EXT_WRITABLE_RST
) (
	input  wire machine_csr_pkg::ext_field_t cur_i,
	input  wire machine_csr_pkg::ext_field_t wr_i,
	output machine_csr_pkg::ext_field_t      legal_o
);
	import machine_csr_pkg::*;

	// ****************************************************************
	// Write-any-read-legal folding of a requested extension set.
	// ****************************************************************
	wire ext_field_t merged = (wr_i & WRITABLE) | (cur_i & ~WRITABLE);
	wire ext_field_t limited = merged & SUPPORTED & ~`EXT_RESERVED;
	// Double float needs single float; asking for double without single drops both.
	wire             df_bad = limited[`EXT_D] & ~limited[`EXT_F];
	wire             q_bad = limited[`EXT_Q] & ~(limited[`EXT_D] & ~df_bad);
	wire ext_field_t joint;

	assign joint = limited & ~(ext_field_t'(df_bad) << `EXT_D)
		& ~(ext_field_t'(df_bad) << `EXT_F)
		& ~(ext_field_t'(q_bad) << `EXT_Q);
	// The reduced base is read-only and always the complement of the full base.
	assign legal_o = (joint & ~(ext_field_t'(1) << `EXT_E))
		| ({25'h0000000, ~joint[`EXT_I]} << `EXT_E);
endmodule : isa_legalizer

/* machine_csr_bank.sv */
`include "machine_csr_consts.svh"

// What this block does
// - Feature field has one bit per letter at the fixed documented positions.
// - Reserved and tentatively reserved feature bits always read zero.
// - Jointly constrained feature bits act as one field; bad combinations become legal.
// - Feature write raising alignment with misaligned next instruction is discarded.
// - Vendor code is a 32-bit read-only register; zero means not implemented.
// - Vendor bank subfield holds continuation count, one below the bank number.
// - Microarchitecture code is a word-wide read-only register; zero allowed.
// - Commercial code has top bit set and nonzero rest; open code nonzero, top clear.
// - Implementation version is always readable; zero means not implemented.
// - Hardware-thread number is word-wide, read-only, unique, and some thread is zero.
// - Machine state is a word-wide read/write register controlling the thread.
// - Upper-half state register holds bits 30:4 only, no dirty or width fields.
// - Upper-half state register is left out when all its bits are zero.
// - Machine width code: 1 is 32, 2 is 64, 3 is 128; resets widest.
module machine_csr_bank #(
	parameter logic [24:0] VENDOR_OFFSET = 25'h0000000,
	parameter logic [6:0]  VENDOR_BANK   = 7'h00,
	parameter logic [31:0] MICROARCH_ID  = 32'h00000000,
	parameter logic [31:0] IMPL_VERSION  = 32'h00000000,
	parameter logic [31:0] HART_NUMBER   = 32'h00000000,
	parameter logic [25:0] EXT_SUPPORTED = `EXT_SUPPORTED_RST,
	parameter logic [25:0] EXT_WRITABLE  = `EXT_WRITABLE_RST,
	parameter logic [31:0] STATE_WMASK   = `STATE_WMASK_RST,
	parameter logic [31:0] UPPER_WMASK   = `UPPER_WMASK_RST
) (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   cyc_i,
	input  wire logic                   stb_i,
	input  wire logic                   we_i,
	input  wire logic [7:0]             adr_i,
	input  wire logic [3:0]             sel_i,
	input  wire machine_csr_pkg::word_t dat_i,
	input  wire machine_csr_pkg::word_t next_pc_i,
	output machine_csr_pkg::word_t      dat_o,
	output logic                        ack_o,
	output logic                        err_o,
	output logic                        illegal_write_o,
	output machine_csr_pkg::word_t      isa_features_o,
	output machine_csr_pkg::word_t      machine_state_o,
	output machine_csr_pkg::word_t      state_upper_o
);
	import machine_csr_pkg::*;

	// ****************************************************************
	// Parameter checks.
	// ****************************************************************
	// The vendor code is the continuation count above the offset within the bank.
	localparam word_t VENDOR_CODE = {VENDOR_BANK, VENDOR_OFFSET};
	localparam logic  UPPER_PRESENT = (UPPER_WMASK != 32'h00000000);
	// Full base wins over the reduced base at reset, so the reset value is already legal.
	localparam ext_field_t EXT_RESET = (EXT_SUPPORTED & ~`EXT_RESERVED & ~(26'h0000001 << `EXT_E))
		| ({25'h0000000, ~EXT_SUPPORTED[`EXT_I]} << `EXT_E);

	generate
		if ((EXT_SUPPORTED & `EXT_RESERVED) != 26'h0000000) begin : g_bad_ext
			$error("Supported feature set names a reserved bit.");
		end
		if ((EXT_WRITABLE & ~EXT_SUPPORTED) != 26'h0000000) begin : g_bad_wr
			$error("Writable feature bit is not supported.");
		end
		if (MICROARCH_ID[31] && MICROARCH_ID[30:0] == 31'h00000000) begin : g_bad_arch
			$error("Commercial microarchitecture code needs nonzero low bits.");
		end
		if ((UPPER_WMASK & ~`UPPER_LEGAL_MASK) != 32'h00000000) begin : g_bad_upper
			$error("Upper-half state bits must lie within 30:4.");
		end
		if (!EXT_SUPPORTED[`EXT_C] && EXT_WRITABLE[`EXT_C]) begin : g_bad_c
			$error("Compressed bit cannot be writable when unsupported.");
		end
		if (EXT_SUPPORTED[`EXT_D] && !EXT_SUPPORTED[`EXT_F]) begin : g_bad_df
			$error("Double float support needs single float support.");
		end
	endgenerate

	// ****************************************************************
	// Functions.
	// ****************************************************************
	function automatic word_t lane_merge(input word_t old, input word_t nw, input logic [3:0] sel);
		word_t r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction : lane_merge

	function automatic logic at(input logic [7:0] adr, input logic [7:0] ofs);
		return adr == ofs;
	endfunction : at

	// ****************************************************************
	// State.
	// ****************************************************************
	bus_state_t bus_reg;
	bus_state_t bus_next;
	ext_field_t ext_reg;
	ext_field_t ext_next;
	word_t      state_reg;
	word_t      state_next;
	word_t      upper_reg;
	word_t      upper_next;
	word_t      rdata_next;
	logic       ack_next;
	logic       err_next;

	// ****************************************************************
	// Decode.
	// ****************************************************************
	wire   req = cyc_i & stb_i & (bus_reg == bus_idle);
	wire   hit_isa = at(adr_i, `OFS_ISA_FEATURES);
	wire   hit_vendor = at(adr_i, `OFS_VENDOR_CODE);
	wire   hit_arch = at(adr_i, `OFS_MICROARCH_ID);
	wire   hit_impl = at(adr_i, `OFS_IMPL_VERSION);
	wire   hit_hart = at(adr_i, `OFS_HART_NUMBER);
	wire   hit_state = at(adr_i, `OFS_MACHINE_STATE);
	wire   hit_upper = at(adr_i, `OFS_STATE_UPPER) & UPPER_PRESENT;
	wire   hit_ro = hit_vendor | hit_arch | hit_impl | hit_hart;
	wire   hit_any = hit_ro | hit_isa | hit_state | hit_upper;
	wire   bad_req = req & (~hit_any | (we_i & hit_ro));
	wire   wr_ok = req & we_i & ~bad_req;

	// The width field is fixed: this bank serves a 32-bit-only hart, so the widest setting is 32.
	wire word_t isa_word = {`WIDTH_CODE_32, 4'h0, ext_reg};
	wire word_t isa_written = lane_merge(isa_word, dat_i, sel_i);
	wire ext_field_t ext_legal;

	isa_legalizer #(
		.SUPPORTED(EXT_SUPPORTED),
		.WRITABLE (EXT_WRITABLE)
	) u_legalizer (
		.cur_i  (ext_reg),
		.wr_i   (isa_written[25:0]),
		.legal_o(ext_legal)
	);

	// Dropping compressed raises the fetch alignment from 16 to 32 bits.
	wire   align_rises = ext_reg[`EXT_C] & ~ext_legal[`EXT_C];
	wire   isa_suppress = align_rises & next_pc_i[1];

	wire word_t read_word =
		hit_isa    ? isa_word :
		hit_vendor ? VENDOR_CODE :
		hit_arch   ? MICROARCH_ID :
		hit_impl   ? IMPL_VERSION :
		hit_hart   ? HART_NUMBER :
		hit_state  ? state_reg :
		hit_upper  ? upper_reg : 32'h00000000;

	// ****************************************************************
	// Next-state logic.
	// ****************************************************************
	always_comb begin
		bus_next = bus_idle;
		ack_next = 1'b0;
		err_next = 1'b0;
		rdata_next = 32'h00000000;
		ext_next = ext_reg;
		state_next = state_reg;
		upper_next = upper_reg;
		unique case (bus_reg)
			bus_idle: begin
				if (req) begin
					bus_next = bus_answer;
					ack_next = ~bad_req;
					err_next = bad_req;
					rdata_next = (we_i | bad_req) ? 32'h00000000 : read_word;
				end
			end
			bus_answer: begin
				bus_next = bus_idle;
			end
		endcase
		if (wr_ok & hit_isa & ~isa_suppress) begin
			ext_next = ext_legal;
		end
		if (wr_ok & hit_state) begin
			state_next = (lane_merge(state_reg, dat_i, sel_i) & STATE_WMASK)
				| (state_reg & ~STATE_WMASK);
		end
		if (wr_ok & hit_upper) begin
			upper_next = lane_merge(upper_reg, dat_i, sel_i) & UPPER_WMASK;
		end
	end

	// ****************************************************************
	// Registers.
	// ****************************************************************
	// The write lands on the edge that raises the answer, so a read right after sees it.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_reg <= bus_idle;
			ext_reg <= EXT_RESET;
			state_reg <= 32'h00000000;
			upper_reg <= 32'h00000000;
		end else begin
			bus_reg <= bus_next;
			ext_reg <= ext_next;
			state_reg <= state_next;
			upper_reg <= upper_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			illegal_write_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= ack_next;
			err_o <= err_next;
			illegal_write_o <= req & we_i & hit_ro;
			dat_o <= rdata_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			isa_features_o <= {`WIDTH_CODE_32, 4'h0, EXT_RESET};
			machine_state_o <= 32'h00000000;
			state_upper_o <= 32'h00000000;
		end else begin
			isa_features_o <= {`WIDTH_CODE_32, 4'h0, ext_next};
			machine_state_o <= state_next;
			state_upper_o <= upper_next;
		end
	end

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	wire ext_bits_c = isa_written[`EXT_C];
	wire ext_field_t ext_extra = isa_features_o[25:0] & ~EXT_SUPPORTED & ~(26'h0000001 << `EXT_E);

	a_answer_once: assert property (req |=> (ack_o ^ err_o) ##1 !(ack_o | err_o))
		else $error("Bus answer not a single one-cycle pulse.");
	a_reserved_zero: assert property ((isa_features_o[25:0] & `EXT_RESERVED) == 26'h0000000)
		else $error("Reserved feature bit reads nonzero.");
	a_reduced_base: assert property (isa_features_o[`EXT_E] == ~isa_features_o[`EXT_I])
		else $error("Reduced base bit is not the complement of full base.");
	a_double_needs: assert property (isa_features_o[`EXT_D] |-> isa_features_o[`EXT_F])
		else $error("Double float enabled without single float.");
	a_align_keep: assert property (wr_ok && hit_isa && isa_suppress |=> $stable(ext_reg))
		else $error("Feature write applied despite misaligned next instruction.");
	a_vendor_read: assert property (req && !we_i && hit_vendor |=> ack_o && dat_o == VENDOR_CODE)
		else $error("Vendor code read wrong.");
	a_hart_read: assert property (req && !we_i && hit_hart |=> ack_o && dat_o == HART_NUMBER)
		else $error("Thread number read wrong.");
	a_ro_refuse: assert property (req && we_i && hit_ro |=> err_o && illegal_write_o && !ack_o)
		else $error("Read-only write not refused.");
	a_width_code: assert property (!$past(rst_i) |-> isa_features_o[31:30] == `WIDTH_CODE_32)
		else $error("Width code not the 32-bit encoding.");
	a_upper_bits: assert property ((state_upper_o & ~UPPER_WMASK) == 32'h00000000)
		else $error("Upper-half state holds bits outside its field.");
	a_state_write: assert property (wr_ok && hit_state && sel_i == 4'hF
		|=> (machine_state_o & STATE_WMASK) == ($past(dat_i) & STATE_WMASK))
		else $error("Machine state write not stored.");
	a_arch_read: assert property (req && !we_i && hit_arch |=> ack_o && dat_o == MICROARCH_ID)
		else $error("Microarchitecture code read wrong.");
	a_impl_read: assert property (req && !we_i && hit_impl |=> ack_o && dat_o == IMPL_VERSION)
		else $error("Implementation version read wrong.");
	a_err_quiet: assert property (err_o |-> dat_o == 32'h00000000 && !ack_o)
		else $error("Error answer carries data or an acknowledge.");
	a_supported_only: assert property (ext_extra == 26'h0000000)
		else $error("Feature port shows an unsupported extension.");

	c_isa_write: cover property (wr_ok && hit_isa && !isa_suppress);
	c_isa_drop_c: cover property (wr_ok && hit_isa && isa_suppress && !ext_bits_c);
	c_ro_error: cover property (req && we_i && hit_ro);
	c_upper_rw: cover property (wr_ok && hit_upper ##4 req && !we_i && hit_upper);
endmodule : machine_csr_bank

/* machine_csr_consts.svh */
`ifndef MACHINE_CSR_CONSTS_SVH
`define MACHINE_CSR_CONSTS_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define OFS_ISA_FEATURES   8'h00
`define OFS_VENDOR_CODE    8'h04
`define OFS_MICROARCH_ID   8'h08
`define OFS_IMPL_VERSION   8'h0C
`define OFS_HART_NUMBER    8'h10
`define OFS_MACHINE_STATE  8'h14
`define OFS_STATE_UPPER    8'h18

// ****************************************************************
// Feature register layout.
// ****************************************************************
`define EXT_W              26
`define EXT_A              0
`define EXT_C              2
`define EXT_D              3
`define EXT_E              4
`define EXT_F              5
`define EXT_H              7
`define EXT_I              8
`define EXT_M              12
`define EXT_N              13
`define EXT_Q              16
`define EXT_S              18
`define EXT_U              20
`define EXT_X              23
`define EXT_RESERVED       26'h36ACE42
`define EXT_SUPPORTED_RST  26'h010112D
`define EXT_WRITABLE_RST   26'h000102C
`define WIDTH_CODE_LSB     30
`define WIDTH_CODE_32      2'h1
`define WIDTH_CODE_64      2'h2
`define WIDTH_CODE_128     2'h3

// ****************************************************************
// Status register layout.
// ****************************************************************
`define STATE_WMASK_RST    32'h00001888
`define UPPER_WMASK_RST    32'h00000030
`define UPPER_LEGAL_MASK   32'h7FFFFFF0

`endif

/* machine_csr_pkg.sv */
package machine_csr_pkg;
	typedef enum logic {
		bus_idle,
		bus_answer
	} bus_state_t;
	typedef logic [31:0] word_t;
	typedef logic [25:0] ext_field_t;
endpackage : machine_csr_pkg

/* testbench.sv */
`include "machine_csr_consts.svh"

module testbench import machine_csr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Identity values, arbitrary and chosen only to be nonzero, and the expected feature reset word.
	// ****************************************************************
	localparam logic [6:0]  BANK    = 7'h05;
	localparam logic [24:0] OFFSET  = 25'h0000ABC;
	localparam logic [31:0] ARCH_ID = 32'h80000011;
	localparam logic [31:0] IMPL_ID = 32'h12300000;
	localparam logic [31:0] HART_ID = 32'h00000003;
	localparam logic [31:0] FEAT_RST = 32'h40000000 | {6'h00, `EXT_SUPPORTED_RST};

	logic        clk_i;
	logic        rst_i;
	logic        cyc_i;
	logic        stb_i;
	logic        we_i;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i;
	word_t       dat_i;
	word_t       next_pc_i;
	word_t       dat_o;
	logic        ack_o;
	logic        err_o;
	logic        illegal_write_o;
	word_t       isa_features_o;
	word_t       machine_state_o;
	word_t       state_upper_o;
	word_t       rd;
	logic [2:0]  resp;
	int          errors;
	int          check_count;

	machine_csr_bank #(
		.VENDOR_OFFSET (OFFSET),
		.VENDOR_BANK   (BANK),
		.MICROARCH_ID  (ARCH_ID),
		.IMPL_VERSION  (IMPL_ID),
		.HART_NUMBER   (HART_ID)
	) u_dut (
		.clk_i           (clk_i),
		.rst_i           (rst_i),
		.cyc_i           (cyc_i),
		.stb_i           (stb_i),
		.we_i            (we_i),
		.adr_i           (adr_i),
		.sel_i           (sel_i),
		.dat_i           (dat_i),
		.next_pc_i       (next_pc_i),
		.dat_o           (dat_o),
		.ack_o           (ack_o),
		.err_o           (err_o),
		.illegal_write_o (illegal_write_o),
		.isa_features_o  (isa_features_o),
		.machine_state_o (machine_state_o),
		.state_upper_o   (state_upper_o)
	);

	always #4 clk_i = ~clk_i;

	// ****************************************************************
	// Shared tasks.
	// ****************************************************************
	task automatic close_out;
		if (errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out

	task automatic chk(input string what, input word_t exp, input word_t got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Response is sampled before the edge's updates land, so read data and ack belong together.
	task automatic bus(input logic we, input logic [7:0] adr, input word_t d, input logic [3:0] sel);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= we;
		adr_i <= adr;
		sel_i <= sel;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
		rd   = dat_o;
		resp = {ack_o, err_o, illegal_write_o};
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (n >= 20) begin
			errors++;
			close_out();
		end else begin
			@(posedge clk_i);
		end
	endtask : bus

	task automatic rd_chk(input logic [7:0] adr, input word_t exp);
		bus(1'b0, adr, 32'h00000000, 4'hF);
		chk("read response", {29'h0, 3'b100}, {29'h0, resp});
		chk("read data", exp, rd);
	endtask : rd_chk

	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	task automatic t_reset_values;
		rd_chk(`OFS_ISA_FEATURES, FEAT_RST);
		rd_chk(`OFS_VENDOR_CODE, {BANK, OFFSET});
		rd_chk(`OFS_MICROARCH_ID, ARCH_ID);
		rd_chk(`OFS_IMPL_VERSION, IMPL_ID);
		rd_chk(`OFS_HART_NUMBER, HART_ID);
		rd_chk(`OFS_MACHINE_STATE, 32'h00000000);
		rd_chk(`OFS_STATE_UPPER, 32'h00000000);
	endtask : t_reset_values

	task automatic t_ro_writes;
		logic [7:0] ofs [4];
		word_t      val [4];
		ofs = '{`OFS_VENDOR_CODE, `OFS_MICROARCH_ID, `OFS_IMPL_VERSION, `OFS_HART_NUMBER};
		val = '{{BANK, OFFSET}, ARCH_ID, IMPL_ID, HART_ID};
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, ofs[i], 32'hFFFFFFFF, 4'hF);
			chk("read-only write response", {29'h0, 3'b011}, {29'h0, resp});
			rd_chk(ofs[i], val[i]);
		end
	endtask : t_ro_writes

	task automatic t_feature_write_any_read_legal;
		bus(1'b1, `OFS_ISA_FEATURES, 32'h00000000, 4'hF);
		rd_chk(`OFS_ISA_FEATURES, 32'h40100101);
		bus(1'b1, `OFS_ISA_FEATURES, 32'h00000008, 4'hF);
		rd_chk(`OFS_ISA_FEATURES, 32'h40100101);
		bus(1'b1, `OFS_ISA_FEATURES, 32'hFFFFFFFF, 4'hF);
		rd_chk(`OFS_ISA_FEATURES, FEAT_RST);
		chk("feature port", FEAT_RST, isa_features_o);
	endtask : t_feature_write_any_read_legal

	// Clearing the compressed bit raises alignment; a halfword next address must block it.
	task automatic t_alignment;
		next_pc_i <= 32'h00000002;
		bus(1'b1, `OFS_ISA_FEATURES, 32'hFFFFFFFB, 4'hF);
		rd_chk(`OFS_ISA_FEATURES, FEAT_RST);
		next_pc_i <= 32'h00000004;
		bus(1'b1, `OFS_ISA_FEATURES, 32'hFFFFFFFB, 4'hF);
		rd_chk(`OFS_ISA_FEATURES, 32'h40101129);
	endtask : t_alignment

	task automatic t_state;
		bus(1'b1, `OFS_MACHINE_STATE, 32'hFFFFFFFF, 4'hF);
		rd_chk(`OFS_MACHINE_STATE, `STATE_WMASK_RST);
		bus(1'b1, `OFS_MACHINE_STATE, 32'h00000000, 4'h2);
		rd_chk(`OFS_MACHINE_STATE, 32'h00000088);
		chk("state port", 32'h00000088, machine_state_o);
		bus(1'b1, `OFS_STATE_UPPER, 32'hFFFFFFFF, 4'hF);
		rd_chk(`OFS_STATE_UPPER, `UPPER_WMASK_RST & `UPPER_LEGAL_MASK);
		chk("upper port", 32'h00000030, state_upper_o);
	endtask : t_state

	task automatic t_unmapped;
		bus(1'b1, 8'h1C, 32'hFFFFFFFF, 4'hF);
		chk("unmapped write response", {29'h0, 3'b010}, {29'h0, resp});
		bus(1'b0, 8'h02, 32'h00000000, 4'hF);
		chk("misaligned read response", {29'h0, 3'b010}, {29'h0, resp});
		chk("misaligned read data", 32'h00000000, rd);
	endtask : t_unmapped

	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 8'h00;
		sel_i = 4'h0;
		dat_i = 32'h00000000;
		next_pc_i = 32'h00000000;
		errors = 0;
		check_count = 0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset_values();
		t_ro_writes();
		t_feature_write_any_read_legal();
		t_alignment();
		t_state();
		t_unmapped();
		close_out();
	end
endmodule : testbench
